// [hw/psfs_min_pulse.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Three-state PWM driver with optional minimum high-pulse stretching.
// ====================
module psfs_min_pulse #(
    parameter int CW = 8
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire logic          pwm_req,
    input  wire logic          active,
    input  wire logic          min_en,
    input  wire logic [CW-1:0] min_cyc,
    output logic               pwm_o,
    output logic               pwm_oe_n
);

    logic          hi_r;
    logic          hi_nxt;
    logic          drv_r;
    logic          drv_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // ====================
    // Pulse stretching.
    // ====================
    // An inactive channel parks at mid-level at once; shutdown must never
    // wait for a stretched pulse to finish.
    always_comb begin
        hi_nxt  = 1'b0;
        drv_nxt = active;
        cnt_nxt = '0;
        if (active) begin
            if (hi_r && cnt_r != '0) begin
                hi_nxt  = 1'b1;
                cnt_nxt = cnt_r - 1'b1;
            end else if (pwm_req && !hi_r) begin
                hi_nxt = 1'b1;
                if (min_en && min_cyc > 1) begin
                    cnt_nxt = min_cyc - 1'b1;
                end
            end else begin
                hi_nxt = pwm_req;
            end
        end
    end

    // Registers only.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hi_r  <= 1'b0;
            drv_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            hi_r  <= hi_nxt;
            drv_r <= drv_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // High, low or mid-level off toward the stage.
    assign pwm_o    = hi_r;
    assign pwm_oe_n = ~drv_r;

endmodule : psfs_min_pulse
`default_nettype wire

// [hw/psfs_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Power stage fault supervision, status bits, temperature and PWM drive.
// ====================
// How it works
// - Stage fault sets OV, current bit, drops ready.
// - Stage UV sets OV only while running.
// - UV detection only when mode bit 0 set.
// - Ready flags low during enabled UV detection.
// - OV conditions except open: immediate off, no retry.
// - Test remote-sense lines at every reset.
// - Open sense: all off, OV and UV, not ready.
// - Open latched until retest after full reset.
// - Stage event during output UV sets both bits.
// - Current bit and ready flags follow live state.
// - Mode bit 1 enforces minimum PWM pulse width.
// - Bus voltage converted to temperature, slope, offset.
// - Each PWM output drives high, low or mid.
module psfs_top #(
    parameter int          NCH = psfs_pkg::NCH,
    parameter int          MW  = 8,
    parameter int unsigned SETTLE_CYC = psfs_pkg::SENSE_SETTLE_CYC
) (
    input  wire logic                              mclk,
    input  wire logic                              reset_n,
    input  wire logic                              hsel,
    input  wire logic [31:0]                       haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [31:0]                       hwdata,
    input  wire logic                              hready,
    output logic      [31:0]                       hrdata,
    output logic                                   hreadyout,
    output logic                                   hresp,
    input  wire psfs_pkg::psfs_chan_pins_t [NCH-1:0] chan_pins,
    input  wire logic                              gate_drive_supply_monitor,
    input  wire logic                              adc_valid,
    input  wire logic                              adc_chan,
    input  wire logic [11:0]                       adc_mv,
    input  wire logic [NCH-1:0]                    pwm_req,
    output logic      [NCH-1:0]                    pwm_o,
    output logic      [NCH-1:0]                    pwm_oe_n,
    output logic      [NCH-1:0]                    rail_on,
    output logic                                   irq
);

    localparam int PW = $bits(psfs_pkg::psfs_chan_pins_t) * NCH + 1;
    localparam int EW = $bits(psfs_pkg::psfs_evt_t);

    // ====================
    // Pin synchronisers.
    // ====================
    logic [PW-1:0]                     pin_meta_r;
    logic [PW-1:0]                     pin_sync_r;
    psfs_pkg::psfs_chan_pins_t [NCH-1:0] pin_s;
    logic                              gd_uv;

    // Two flops before anything reads the stage and monitor levels.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= {gate_drive_supply_monitor, chan_pins};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign pin_s = pin_sync_r[PW-2:0];
    assign gd_uv = pin_sync_r[PW-1];

    // ====================
    // AHB-Lite address phase capture.
    // ====================
    logic       wr_pend_r;
    logic [7:0] wr_addr_r;
    logic       addr_ok;

    // Zero-wait slave: every transfer completes with OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    // ====================
    // Remote-sense test sequencer.
    // ====================
    psfs_pkg::psfs_test_t test_r;
    psfs_pkg::psfs_test_t test_nxt;
    logic [15:0]          tcnt_r;
    logic [15:0]          tcnt_nxt;
    logic                 open_r;
    logic                 open_nxt;
    logic                 full_rst;
    logic                 any_open;

    assign full_rst = wr_pend_r && wr_addr_r == psfs_pkg::OFF_RESET;

    always_comb begin
        any_open = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            any_open = any_open | pin_s[c].sense_open;
        end
    end

    // A commanded full reset reruns the test; apart from reset, nothing else clears an open.
    always_comb begin
        test_nxt = test_r;
        tcnt_nxt = tcnt_r;
        open_nxt = open_r;
        if (full_rst) begin
            test_nxt = psfs_pkg::PSFS_SETTLE;
            tcnt_nxt = '0;
            open_nxt = 1'b0;
        end else begin
            case (test_r)
                psfs_pkg::PSFS_SETTLE: begin
                    tcnt_nxt = tcnt_r + 1'b1;
                    if (tcnt_r >= 16'(SETTLE_CYC - 1)) begin
                        test_nxt = psfs_pkg::PSFS_CHECK;
                    end
                end
                psfs_pkg::PSFS_CHECK: begin
                    open_nxt = any_open;
                    test_nxt = psfs_pkg::PSFS_DONE;
                end
                psfs_pkg::PSFS_DONE: begin
                    test_nxt = psfs_pkg::PSFS_DONE;
                end
                default: begin
                    test_nxt = psfs_pkg::PSFS_SETTLE;
                end
            endcase
        end
    end

    // Reset always starts a fresh test of both lines.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            test_r <= psfs_pkg::PSFS_SETTLE;
            tcnt_r <= '0;
            open_r <= 1'b0;
        end else begin
            test_r <= test_nxt;
            tcnt_r <= tcnt_nxt;
            open_r <= open_nxt;
        end
    end

    // ====================
    // Control, status and interrupt registers.
    // ====================
    logic [NCH-1:0]    run_r,    run_nxt;
    logic              vdr_r,    vdr_nxt;
    logic [3:0]        mode_r,   mode_nxt;
    logic [MW-1:0]     minw_r,   minw_nxt;
    logic [15:0]       slope_r,  slope_nxt;
    logic [15:0]       zero_r,   zero_nxt;
    logic [15:0]       vout_r,   vout_nxt;
    logic [NCH-1:0]    trip_r,   trip_nxt;
    logic [EW-1:0]     ists_r,   ists_nxt;
    logic [EW-1:0]     imask_r,  imask_nxt;
    logic [NCH-1:0]    uv_det;
    logic [NCH-1:0]    ready;
    logic [NCH-1:0]    ov_cond;
    logic [NCH-1:0]    uv_cond;
    logic [NCH-1:0]    on_nxt;
    psfs_pkg::psfs_evt_t evt;
    logic              wr_ctrl;

    assign wr_ctrl = wr_pend_r && !full_rst;

    // Live per-channel conditions.
    always_comb begin
        evt = '0;
        for (int c = 0; c < NCH; c++) begin
            // Bus UV or the shared gate-drive monitor, only when enabled.
            uv_det[c] = mode_r[c*psfs_pkg::MODE_STRIDE
                               + psfs_pkg::MODE_UV_EN]
                        && (vdr_r ? gd_uv : pin_s[c].stage_uv);
            ov_cond[c] = pin_s[c].vout_ov
                       || pin_s[c].stage_fault
                       || (uv_det[c] && run_r[c]);
            uv_cond[c] = pin_s[c].vout_uv;
            ready[c]   = !(uv_det[c] || pin_s[c].stage_fault
                         || pin_s[c].vout_ov || pin_s[c].vout_uv
                         || open_r);
            on_nxt[c]  = run_r[c] && !trip_r[c] && !open_r
                       && test_r == psfs_pkg::PSFS_DONE;
            evt.vout_ov[c]     = ov_cond[c] || open_r;
            evt.vout_uv[c]     = uv_cond[c] || open_r;
            evt.stage_fault[c] = pin_s[c].stage_fault;
        end
        evt.sense_open = open_r;
    end

    // Register writes; hardware sets beat software clears in one cycle.
    always_comb begin
        run_nxt   = run_r;
        vdr_nxt   = vdr_r;
        mode_nxt  = mode_r;
        minw_nxt  = minw_r;
        slope_nxt = slope_r;
        zero_nxt  = zero_r;
        vout_nxt  = vout_r;
        ists_nxt  = ists_r;
        imask_nxt = imask_r;
        if (wr_ctrl) begin
            case (wr_addr_r)
                psfs_pkg::OFF_CTRL: begin
                    run_nxt = hwdata[NCH-1:0];
                    vdr_nxt = hwdata[psfs_pkg::CTRL_VDR_SEL];
                end
                psfs_pkg::OFF_PWM_MODE: mode_nxt  = hwdata[3:0];
                psfs_pkg::OFF_MIN_W:    minw_nxt  = hwdata[MW-1:0];
                psfs_pkg::OFF_SLOPE:    slope_nxt = hwdata[15:0];
                psfs_pkg::OFF_ZERO:     zero_nxt  = hwdata[15:0];
                psfs_pkg::OFF_STS_VOUT: vout_nxt  = vout_r & ~hwdata[15:0];
                psfs_pkg::OFF_IRQ_STS:  ists_nxt  = ists_r & ~hwdata[EW-1:0];
                psfs_pkg::OFF_IRQ_MASK: imask_nxt = hwdata[EW-1:0];
                default: begin
                end
            endcase
        end
        // A full reset wipes fault history; configuration is kept.
        if (full_rst) begin
            vout_nxt = '0;
            ists_nxt = '0;
        end
        for (int c = 0; c < NCH; c++) begin
            // Both bits may end up set together: rule of accumulation.
            if (evt.vout_ov[c]) begin
                vout_nxt[c*psfs_pkg::VOUT_STRIDE
                         + psfs_pkg::VOUT_OV_BIT] = 1'b1;
            end
            if (evt.vout_uv[c]) begin
                vout_nxt[c*psfs_pkg::VOUT_STRIDE
                         + psfs_pkg::VOUT_UV_BIT] = 1'b1;
            end
            // Latched off with no retry until software drops the run bit or commands a full reset.
            trip_nxt[c] = run_nxt[c] && !full_rst
                          && (trip_r[c] || ov_cond[c]);
        end
        ists_nxt = ists_nxt | evt;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            run_r   <= '0;
            vdr_r   <= 1'b0;
            mode_r  <= psfs_pkg::RST_PWM_MODE;
            minw_r  <= MW'(psfs_pkg::RST_MIN_W);
            slope_r <= psfs_pkg::RST_SLOPE;
            zero_r  <= psfs_pkg::RST_ZERO;
            vout_r  <= '0;
            trip_r  <= '0;
            ists_r  <= '0;
            imask_r <= '0;
            rail_on <= '0;
            irq     <= 1'b0;
        end else begin
            run_r   <= run_nxt;
            vdr_r   <= vdr_nxt;
            mode_r  <= mode_nxt;
            minw_r  <= minw_nxt;
            slope_r <= slope_nxt;
            zero_r  <= zero_nxt;
            vout_r  <= vout_nxt;
            trip_r  <= trip_nxt;
            ists_r  <= ists_nxt;
            imask_r <= imask_nxt;
            rail_on <= on_nxt;
            irq     <= |(ists_nxt & imask_nxt);
        end
    end

    // ====================
    // Temperature conversion from the monitor converter samples.
    // ====================
    logic [15:0]        temp_r [NCH];
    logic [15:0]        temp_nxt [NCH];
    logic signed [16:0] tdiff;
    logic signed [33:0] tprod;

    // Degrees = (bus mV - zero offset mV) * slope coefficient, Q8.8.
    always_comb begin
        tdiff = $signed({5'h00, adc_mv}) - $signed({1'b0, zero_r});
        tprod = tdiff * $signed({1'b0, slope_r});
        for (int c = 0; c < NCH; c++) begin
            temp_nxt[c] = temp_r[c];
            if (adc_valid && adc_chan == c[0]) begin
                temp_nxt[c] = tprod[psfs_pkg::TEMP_FRAC +: 16];
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int c = 0; c < NCH; c++) begin
            if (!reset_n) begin
                temp_r[c] <= '0;
            end else begin
                temp_r[c] <= temp_nxt[c];
            end
        end
    end

    // ====================
    // Read data, loaded during the address phase.
    // ====================
    logic [31:0] rd_nxt;
    logic [31:0] iout_w;
    logic [31:0] pad_w;

    // Current bit and ready flags are live, never latched.
    always_comb begin
        iout_w = '0;
        pad_w  = '0;
        for (int c = 0; c < NCH; c++) begin
            iout_w[c*psfs_pkg::VOUT_STRIDE + psfs_pkg::IOUT_FLT_BIT] =
                pin_s[c].stage_fault;
            pad_w[psfs_pkg::PAD_READY_LSB + c] = ready[c];
        end
    end

    always_comb begin
        rd_nxt = '0;
        case (haddr[7:0])
            psfs_pkg::OFF_CTRL:     rd_nxt = {29'h0, vdr_r, run_r};
            psfs_pkg::OFF_PWM_MODE: rd_nxt = {28'h0, mode_r};
            psfs_pkg::OFF_MIN_W:    rd_nxt = 32'(minw_r);
            psfs_pkg::OFF_STS_VOUT: rd_nxt = {16'h0, vout_r};
            psfs_pkg::OFF_STS_IOUT: rd_nxt = iout_w;
            psfs_pkg::OFF_PAD:      rd_nxt = pad_w;
            psfs_pkg::OFF_SLOPE:    rd_nxt = {16'h0, slope_r};
            psfs_pkg::OFF_ZERO:     rd_nxt = {16'h0, zero_r};
            psfs_pkg::OFF_TEMP:     rd_nxt = {temp_r[1], temp_r[0]};
            psfs_pkg::OFF_IRQ_STS:  rd_nxt = 32'(ists_r);
            psfs_pkg::OFF_IRQ_MASK: rd_nxt = 32'(imask_r);
            psfs_pkg::OFF_RAIL:     rd_nxt = {24'h0, test_r, open_r,
                                              1'b0, trip_r, rail_on};
            default:                rd_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // ====================
    // PWM drivers, one per channel.
    // ====================
    for (genvar g = 0; g < NCH; g++) begin : g_pwm
        psfs_min_pulse #(
            .CW (MW)
        ) u_drv (
            .mclk     (mclk),
            .reset_n  (reset_n),
            .pwm_req  (pwm_req[g]),
            .active   (rail_on[g]),
            .min_en   (mode_r[g*psfs_pkg::MODE_STRIDE
                              + psfs_pkg::MODE_MIN_EN]),
            .min_cyc  (minw_r),
            .pwm_o    (pwm_o[g]),
            .pwm_oe_n (pwm_oe_n[g])
        );
    end

endmodule : psfs_top
`default_nettype wire

// [pkg/psfs_pkg.sv]
`default_nettype none
// ====================
// Shared constants and types for the power stage supervision block.
// ====================
package psfs_pkg;

    localparam int NCH = 2;

    // ======================================================================
    // Register byte offsets on the AHB-Lite port.
    // ======================================================================
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PWM_MODE = 8'h04;
    localparam logic [7:0] OFF_MIN_W    = 8'h08;
    localparam logic [7:0] OFF_STS_VOUT = 8'h0c;
    localparam logic [7:0] OFF_STS_IOUT = 8'h10;
    localparam logic [7:0] OFF_PAD      = 8'h14;
    localparam logic [7:0] OFF_SLOPE    = 8'h18;
    localparam logic [7:0] OFF_ZERO     = 8'h1c;
    localparam logic [7:0] OFF_TEMP     = 8'h20;
    localparam logic [7:0] OFF_RESET    = 8'h24;
    localparam logic [7:0] OFF_IRQ_STS  = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFF_RAIL     = 8'h30;

    // ======================================================================
    // Field positions.
    // ======================================================================
    localparam int CTRL_VDR_SEL  = 2;  // Gate-drive monitor replaces bus UV.
    localparam int MODE_UV_EN    = 0;  // Per-channel field bit: UV detect.
    localparam int MODE_MIN_EN   = 1;  // Per-channel field bit: min pulse.
    localparam int MODE_STRIDE   = 2;  // Bits per channel in mode register.
    localparam int VOUT_OV_BIT   = 7;
    localparam int VOUT_UV_BIT   = 4;
    localparam int IOUT_FLT_BIT  = 3;
    localparam int VOUT_STRIDE   = 8;  // Bits per channel in status words.
    localparam int PAD_READY_LSB = 14; // Channel 0 ready, channel 1 above.
    localparam int TEMP_FRAC     = 8;  // Slope coefficient is Q8.8.

    // ======================================================================
    // Values after reset.
    // ======================================================================
    localparam logic [3:0]  RST_PWM_MODE = 4'ha;     // 2'b10 per channel.
    localparam logic [15:0] RST_SLOPE    = 16'h0020; // 1/8 degree per mV.
    localparam logic [15:0] RST_ZERO     = 16'h0258; // 600 mV at 0 degrees.
    localparam logic [7:0]  RST_MIN_W    = 8'h04;

    // ======================================================================
    // Timing: remote-sense test settle time before the lines are judged.
    // ======================================================================
    localparam int CLK_PERIOD_NS   = 50;
    localparam int SENSE_SETTLE_NS = 10000;
    localparam int SENSE_SETTLE_CYC =
        (SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Remote-sense test sequencer states.
    typedef enum logic [1:0] {
        PSFS_SETTLE = 2'b00,
        PSFS_CHECK  = 2'b01,
        PSFS_DONE   = 2'b10
    } psfs_test_t;

    // Per-channel pin levels from the stage side and the output monitors.
    typedef struct packed {
        logic stage_fault;  // Fault level decoded from the shared bus.
        logic stage_uv;     // Stage UV level decoded from the shared bus.
        logic vout_ov;      // Genuine output overvoltage comparator.
        logic vout_uv;      // Genuine output undervoltage comparator.
        logic sense_open;   // Positive remote-sense line found open.
    } psfs_chan_pins_t;

    // Sticky interrupt events.
    typedef struct packed {
        logic       sense_open;
        logic [1:0] stage_fault;
        logic [1:0] vout_uv;
        logic [1:0] vout_ov;
    } psfs_evt_t;

endpackage : psfs_pkg
`default_nettype wire

// [tb/power_stage_fault_status_test.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Bench of the supervision block.
module power_stage_fault_status_test;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hwrite = 1'b0;
    logic        adc_valid = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [1:0]  pwm_req = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [11:0] adc_mv = 12'h0;
    logic [9:0]  lvl = 10'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        irq;
    logic [1:0]  pwm_o;
    logic [1:0]  pwm_oe_n;
    logic [1:0]  rail_on;
    logic [7:0]  hi_w;
    psfs_pkg::psfs_chan_pins_t [1:0] pins;
    int          fails = 0;
    int          n_checks = 0;
    // Half period of 25 ns gives 20 MHz.
    always #25 mclk = ~mclk;
    psfs_top #(.SETTLE_CYC(4)) dut_u (.mclk(mclk), .reset_n(reset_n),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .chan_pins(pins),
        .gate_drive_supply_monitor(1'b0), .adc_valid(adc_valid),
        .adc_chan(1'b0), .adc_mv(adc_mv), .pwm_req(pwm_req), .pwm_o(pwm_o),
        .pwm_oe_n(pwm_oe_n), .rail_on(rail_on), .irq(irq));
    psfs_stage_model stage_u (.lvl(lvl), .mclk(mclk), .pwm_o(pwm_o),
        .pwm_oe_n(pwm_oe_n), .pins(pins), .hi_w(hi_w));
    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One single transfer; both phases wait on hready under one bound.
    task automatic xf(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        int i;
        i = 0;
        @(posedge mclk);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin @(posedge mclk); i++; end while (!hreadyout && i < 40);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge mclk); i++; end while (!hreadyout && i < 40);
        q = hrdata;
        if (i >= 40) begin fails++; results(); end
    endtask : xf
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xf(a, 1'b1, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] q;
        xf(a, 1'b0, 32'h0, q);
        chk(q & m, e);
    endtask : rc
    // Covers the two-flop pin synchroniser and the registers behind it.
    task automatic wt();
        repeat (6) @(posedge mclk);
    endtask : wt
    task automatic wdone();
        logic [31:0] q;
        int i;
        i = 0;
        do begin xf(8'h30, 1'b0, 32'h0, q); i++; end
            while (q[7:6] !== 2'h2 && i < 20);
        if (i >= 20) begin fails++; results(); end
        repeat (2) @(posedge mclk);
    endtask : wdone
    task automatic s_uv();
        wr(8'h04, 32'hb);
        lvl <= 10'h008;
        wt();
        rc(8'h14, 32'h4000, 32'h0);
        rc(8'h0c, 32'h80, 32'h0);
        wr(8'h04, 32'ha);
        rc(8'h14, 32'h4000, 32'h4000);
        lvl <= 10'h0;
    endtask : s_uv
    // Stage fault on a running channel, then recovery and interrupt.
    task automatic s_flt();
        rc(8'h14, 32'hc000, 32'hc000);
        wr(8'h00, 32'h3);
        wr(8'h2c, 32'h20);
        lvl <= 10'h200;
        wt();
        chk(32'(rail_on), 32'h1);
        rc(8'h0c, 32'h8000, 32'h8000);
        rc(8'h10, 32'h800, 32'h800);
        chk(32'(irq), 32'h1);
        lvl <= 10'h0;
        wt();
        rc(8'h10, 32'h800, 32'h0);
        rc(8'h14, 32'h8000, 32'h8000);
        wr(8'h28, 32'h20);
        wt();
        chk(32'(irq), 32'h0);
        wr(8'h00, 32'h1);
    endtask : s_flt
    task automatic s_pwm();
        wr(8'h08, 32'h6);
        pwm_req <= 2'b01;
        @(posedge mclk);
        pwm_req <= 2'b00;
        repeat (2) wt();
        chk(32'(hi_w), 32'h6);
        chk(32'(pwm_oe_n), 32'h2);
        adc_mv <= 12'd700;
        adc_valid <= 1'b1;
        @(posedge mclk);
        adc_valid <= 1'b0;
        rc(8'h20, 32'hffff, ((32'd700 - 32'h258) * 32'h20) >> 8);
    endtask : s_pwm
    task automatic s_ov();
        lvl <= 10'h004;
        wt();
        chk(32'(rail_on), 32'h0);
        rc(8'h0c, 32'h80, 32'h80);
        lvl <= 10'h002;
        wt();
        rc(8'h0c, 32'h10, 32'h10);
        lvl <= 10'h0;
        wt();
        chk(32'(rail_on), 32'h0);
    endtask : s_ov
    task automatic s_open();
        wr(8'h00, 32'h3);
        lvl <= 10'h001;
        wr(8'h24, 32'h1);
        wdone();
        rc(8'h30, 32'h20, 32'h20);
        rc(8'h0c, 32'h90, 32'h90);
        chk(32'(rail_on), 32'h0);
        lvl <= 10'h0;
        wt();
        rc(8'h30, 32'h20, 32'h20);
        wr(8'h24, 32'h1);
        wdone();
        chk(32'(rail_on), 32'h3);
    endtask : s_open
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        rc(8'h04, 32'hf, 32'(psfs_pkg::RST_PWM_MODE));
        rc(8'h3c, 32'hffffffff, 32'h0);
        wdone();
        s_uv();
        s_flt();
        s_pwm();
        s_ov();
        s_open();
        results();
    end
endmodule : power_stage_fault_status_test
bind psfs_top psfs_asserts #(.NCH(NCH), .SETTLE_CYC(SETTLE_CYC)) chk_u (
    .mclk(mclk), .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
    .chan_pins(chan_pins), .rail_on(rail_on), .pwm_oe_n(pwm_oe_n),
    .irq(irq));
`default_nettype wire

// [tb/psfs_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checks of the supervision block.
module psfs_asserts #(
    parameter int          NCH        = 2,
    parameter int unsigned SETTLE_CYC = 4
) (
    input wire logic                             mclk,
    input wire logic                             reset_n,
    input wire logic                             hreadyout,
    input wire logic                             hresp,
    input wire psfs_pkg::psfs_chan_pins_t [NCH-1:0] chan_pins,
    input wire logic [NCH-1:0]                   rail_on,
    input wire logic [NCH-1:0]                   pwm_oe_n,
    input wire logic                             irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [15:0] age_r;
    logic [15:0] age_nxt;
    // Saturating age since reset release, so it never wraps to zero.
    always_comb age_nxt = (age_r == 16'hffff) ? age_r : age_r + 16'h1;
    always_ff @(posedge mclk) age_r <= reset_n ? age_nxt : 16'h0;
    sequence s_trip0;
        chan_pins[0].vout_ov && rail_on[0];
    endsequence
    sequence s_held0;
        (!rail_on[0] && chan_pins[0].vout_ov) [*3];
    endsequence
    property p_ov0; s_trip0 |-> ##[1:6] !rail_on[0]; endproperty
    property p_flt1;
        chan_pins[1].stage_fault && rail_on[1] |-> ##[1:6] !rail_on[1];
    endproperty
    property p_noretry; s_held0 |=> !rail_on[0]; endproperty
    property p_mid0; $fell(rail_on[0]) |-> ##[0:1] pwm_oe_n[0]; endproperty
    property p_drv1;
        !pwm_oe_n[1] |-> rail_on[1] | $past(rail_on[1]);
    endproperty
    property p_okay; hreadyout && !hresp; endproperty
    property p_rstq; $rose(reset_n) |-> !irq && rail_on == '0; endproperty
    property p_settle; age_r < SETTLE_CYC |-> rail_on == '0; endproperty
    a_ov0: assert property (p_ov0) else $error("no trip on ov");
    a_flt1: assert property (p_flt1) else $error("no trip on fault");
    a_noretry: assert property (p_noretry) else $error("retry");
    a_mid0: assert property (p_mid0) else $error("not mid");
    a_drv1: assert property (p_drv1) else $error("drive off");
    a_okay: assert property (p_okay) else $error("bus response");
    a_rstq: assert property (p_rstq) else $error("reset state");
    a_settle: assert property (p_settle) else $error("early rail");
endmodule : psfs_asserts
`default_nettype wire

// [tb/psfs_stage_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Stage pair: pin levels and width of the last driven high pulse on channel 0.
module psfs_stage_model (
    input  wire logic [9:0]  lvl,
    input  wire logic        mclk,
    input  wire logic [1:0]  pwm_o,
    input  wire logic [1:0]  pwm_oe_n,
    output var psfs_pkg::psfs_chan_pins_t [1:0] pins,
    output logic [7:0]       hi_w
);
    logic [7:0] run_w = 8'h0;
    // A mid-level input reads as off, so only a driven high is timed.
    always_ff @(posedge mclk) begin
        pins <= lvl;
        if (!pwm_oe_n[0] && pwm_o[0]) begin
            run_w <= run_w + 8'h1;
        end else if (run_w != 8'h0) begin
            hi_w  <= run_w;
            run_w <= 8'h0;
        end
    end
endmodule : psfs_stage_model
`default_nettype wire
